// *** hdl/dma_channel_control.sv ***
// Control logic of one DMA channel: request source selection, request
// detection, bus mode and unit size, end flag, enable gating and count.
// Assumes a classic Wishbone master and a bus sequencer that pulses
// unit_done_i once per transfer unit moved.
//
// The implementer's own choices: the register offsets and the Wishbone slave port.
module dma_channel_control #(
  parameter int CHAN_ID = 0,
  parameter int CNT_W = 24
) (
  input wire logic clk_i, // System clock, 25 MHz
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic ext_request_n_i, // External request pin, active low
  input wire logic [5:0] periph_req_n_i, // On-chip requests, active low
  input wire logic nmi_i, // Non-maskable interrupt event pulse
  input wire logic addr_err_i, // Address error event pulse
  input wire logic unit_done_i, // Sequencer moved one unit
  output logic unit_req_o, // Unit transfer requested
  output dma_pkg::unit_cmd_t unit_cmd_o, // Size and mode of the unit
  output logic ext_acknowledge_o, // Acknowledge to external device
  output logic completion_irq_o // Completion interrupt request
);

  localparam logic PIN_OK = (CHAN_ID < 2);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] ofs);
    return adr[7:2] == ofs[7:2];
  endfunction

  function automatic logic [31:0] pack_ctrl(input dma_pkg::chan_ctrl_t c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[dma_pkg::RS_LSB +: 4] = c.rsrc;
    w[dma_pkg::DS_BIT] = c.ds;
    w[dma_pkg::TM_BIT] = c.tm;
    w[dma_pkg::TS_LSB +: 2] = c.ts;
    w[dma_pkg::IE_BIT] = c.ie;
    w[dma_pkg::TE_BIT] = c.te;
    w[dma_pkg::DE_BIT] = c.de;
    return w;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dma_pkg::chan_ctrl_t ctrl_q;
  dma_pkg::chan_ctrl_t ctrl_d;
  dma_pkg::chan_state_t state_q;
  dma_pkg::chan_state_t state_d;
  dma_pkg::unit_cmd_t cmd_d;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic dme_q;
  logic nmi_flag_q;
  logic ae_q;
  logic te_seen_q;
  logic nmi_flag_seen_q;
  logic ae_seen_q;
  logic pend_q;
  logic pend_d;
  logic ack_q;
  logic [31:0] rdat_q;
  logic unit_req_q;
  dma_pkg::unit_cmd_t cmd_q;
  logic ack_ext_q;
  logic irq_q;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire access = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr = access & wb_we_i;
  wire rd = access & ~wb_we_i;
  wire hit_ctrl = reg_hit(wb_adr_i, dma_pkg::CTRL_OFS);
  wire hit_oper = reg_hit(wb_adr_i, dma_pkg::OPER_OFS);
  wire hit_count = reg_hit(wb_adr_i, dma_pkg::COUNT_OFS);
  wire hit_status = reg_hit(wb_adr_i, dma_pkg::STATUS_OFS);
  wire [31:0] ctrl_word = pack_ctrl(ctrl_q);
  wire [31:0] oper_word = {29'h0, ae_q, nmi_flag_q, dme_q};
  wire [31:0] count_word = 32'(count_q);
  wire [31:0] ctrl_wdat = merge_bytes(ctrl_word, wb_dat_i, wb_sel_i);
  wire [31:0] oper_wdat = merge_bytes(oper_word, wb_dat_i, wb_sel_i);
  wire [31:0] count_wdat = merge_bytes(count_word, wb_dat_i, wb_sel_i);
  wire wr_ctrl = wr & hit_ctrl;
  wire wr_oper = wr & hit_oper;
  wire wr_count = wr & hit_count;

  // ----------------------------------------------------------------
  // Source decode
  // ----------------------------------------------------------------
  wire [3:0] rs = ctrl_q.rsrc;
  wire is_pin_code = (rs == dma_pkg::RS_PIN_DUAL) | (rs == dma_pkg::RS_PIN_TO_DEV) |
                     (rs == dma_pkg::RS_PIN_FROM_DEV);
  wire src_pin = PIN_OK & is_pin_code;
  wire src_auto = (rs == dma_pkg::RS_AUTO);
  wire src_per = (rs >= dma_pkg::RS_PERIPH_FIRST);
  wire [2:0] per_idx = 3'(rs - dma_pkg::RS_PERIPH_FIRST);

  // Prohibited codes match none of the three and never request
  wire enable_ok = ctrl_q.de & dme_q & ~ctrl_q.te & ~nmi_flag_q & ~ae_q;

  // ----------------------------------------------------------------
  // Request detection
  // ----------------------------------------------------------------
  logic [6:0] req_low;
  logic [6:0] req_fall;

  request_detect #(
    .W(7)
  ) u_detect (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .req_n_i({periph_req_n_i, ext_request_n_i}),
    .low_o(req_low),
    .fall_o(req_fall)
  );

  wire per_fall = req_fall[3'(per_idx + 3'h1)];
  wire pin_level_mode = src_pin & ~ctrl_q.ds;
  wire lvl_now = pin_level_mode & req_low[0];
  wire edge_now = (src_pin & ctrl_q.ds & req_fall[0]) |
                  (src_per & per_fall);
  wire req_now = src_auto | lvl_now | pend_q | edge_now;
  wire start_unit = (state_q == dma_pkg::ST_WAIT) & enable_ok & req_now;
  wire last_unit = (count_q == CNT_W'(1));
  wire unit_end = (state_q == dma_pkg::ST_MOVE) & enable_ok & unit_done_i;
  wire finish = unit_end & last_unit;
  wire more_burst = ctrl_q.tm & (src_auto | ~pin_level_mode | req_low[0]);

  // Edge requests are remembered only while enabled, so an edge
  // seen before the channel is enabled never starts a transfer.
  always_comb
  begin
    pend_d = enable_ok & ((pend_q & ~start_unit) |
                          (edge_now & ~(start_unit & ~pend_q)));
  end

  // ----------------------------------------------------------------
  // Channel sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      dma_pkg::ST_IDLE:
      begin
        if (enable_ok && count_q != '0)
          state_d = dma_pkg::ST_WAIT;
      end
      dma_pkg::ST_WAIT:
      begin
        if (!enable_ok)
          state_d = dma_pkg::ST_IDLE;
        else if (start_unit)
          state_d = dma_pkg::ST_MOVE;
      end
      dma_pkg::ST_MOVE:
      begin
        if (!enable_ok)
          state_d = dma_pkg::ST_IDLE;
        else if (unit_done_i)
        begin
          if (last_unit)
            state_d = dma_pkg::ST_IDLE;
          else if (!more_burst)
            state_d = dma_pkg::ST_WAIT;
        end
      end
      default:
        state_d = dma_pkg::ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Register next values
  // ----------------------------------------------------------------
  wire te_clr = wr_ctrl & ~ctrl_wdat[dma_pkg::TE_BIT] & te_seen_q;
  wire nmi_flag_clr = wr_oper & ~oper_wdat[dma_pkg::NMI_FLAG_BIT] & nmi_flag_seen_q;
  wire ae_clr = wr_oper & ~oper_wdat[dma_pkg::AE_BIT] & ae_seen_q;

  always_comb
  begin
    ctrl_d = ctrl_q;
    if (wr_ctrl)
    begin
      ctrl_d.rsrc = ctrl_wdat[dma_pkg::RS_LSB +: 4];
      ctrl_d.ds = PIN_OK & ctrl_wdat[dma_pkg::DS_BIT];
      ctrl_d.tm = ctrl_wdat[dma_pkg::TM_BIT];
      ctrl_d.ts = ctrl_wdat[dma_pkg::TS_LSB +: 2];
      ctrl_d.ie = ctrl_wdat[dma_pkg::IE_BIT];
      ctrl_d.de = ctrl_wdat[dma_pkg::DE_BIT];
    end
    // Setting wins over a same-cycle clear; writing 1 never sets
    ctrl_d.te = finish | (ctrl_q.te & ~te_clr);
  end

  always_comb
  begin
    count_d = count_q;
    if (wr_count)
      count_d = count_wdat[CNT_W-1:0];
    else if (unit_end)
      count_d = count_q - CNT_W'(1);
  end

  always_comb
  begin
    cmd_d.size = ctrl_q.ts;
    cmd_d.burst = ctrl_q.tm;
    cmd_d.single = src_pin & (rs != dma_pkg::RS_PIN_DUAL);
    cmd_d.to_device = src_pin & (rs == dma_pkg::RS_PIN_TO_DEV);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= dma_pkg::chan_ctrl_t'(dma_pkg::CTRL_RST[10:0]);
      count_q <= '0;
      state_q <= dma_pkg::ST_IDLE;
      pend_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      count_q <= count_d;
      state_q <= state_d;
      pend_q <= pend_d;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      {ae_q, nmi_flag_q, dme_q} <= dma_pkg::OPER_RST;
    end
    else
    begin
      if (wr_oper)
        dme_q <= oper_wdat[dma_pkg::DME_BIT];
      nmi_flag_q <= nmi_i | (nmi_flag_q & ~nmi_flag_clr);
      ae_q <= addr_err_i | (ae_q & ~ae_clr);
    end
  end

  // A flag read as 1 arms its clear; any write to the register disarms
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      te_seen_q <= 1'b0;
      nmi_flag_seen_q <= 1'b0;
      ae_seen_q <= 1'b0;
    end
    else
    begin
      if (rd && hit_ctrl)
        te_seen_q <= ctrl_q.te;
      else if (wr_ctrl)
        te_seen_q <= 1'b0;
      if (rd && hit_oper)
      begin
        nmi_flag_seen_q <= nmi_flag_q;
        ae_seen_q <= ae_q;
      end
      else if (wr_oper)
      begin
        nmi_flag_seen_q <= 1'b0;
        ae_seen_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Wishbone answer: one wait state, unmapped reads return zero
  // ----------------------------------------------------------------
  wire [31:0] status_word = {28'h0, enable_ok, pend_q,
                             state_q == dma_pkg::ST_MOVE, state_q != dma_pkg::ST_IDLE};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_word :
                       hit_oper ? oper_word :
                       hit_count ? count_word :
                       hit_status ? status_word : 32'h0000_0000;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= access;
      if (rd)
        rdat_q <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Outputs toward sequencer, requester and interrupt controller
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      unit_req_q <= 1'b0;
      cmd_q <= '0;
      ack_ext_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      unit_req_q <= (state_d == dma_pkg::ST_MOVE);
      cmd_q <= cmd_d;
      ack_ext_q <= (state_d == dma_pkg::ST_MOVE) & src_pin;
      irq_q <= ctrl_d.ie & ctrl_d.te;
    end
  end

  assign wb_dat_o = rdat_q;
  assign wb_ack_o = ack_q;
  assign unit_req_o = unit_req_q;
  assign unit_cmd_o = cmd_q;
  assign ext_acknowledge_o = ack_ext_q;
  assign completion_irq_o = irq_q;

endmodule

// *** hdl/dma_pkg.sv ***
// Shared constants, field layouts and carrier types of one DMA channel
// control block. Assumes a 32-bit classic Wishbone slave port.
package dma_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] OPER_OFS = 8'h04;
  localparam logic [7:0] COUNT_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int DE_BIT = 0;
  localparam int TE_BIT = 1;
  localparam int IE_BIT = 2;
  localparam int TS_LSB = 3;
  localparam int TM_BIT = 5;
  localparam int DS_BIT = 6;
  localparam int RS_LSB = 8;
  localparam int DME_BIT = 0;
  localparam int NMI_FLAG_BIT = 1;
  localparam int AE_BIT = 2;

  // ----------------------------------------------------------------
  // Request source codes and sizes
  // ----------------------------------------------------------------
  localparam logic [3:0] RS_PIN_DUAL = 4'h0;
  localparam logic [3:0] RS_PIN_TO_DEV = 4'h2;
  localparam logic [3:0] RS_PIN_FROM_DEV = 4'h3;
  localparam logic [3:0] RS_AUTO = 4'h4;
  localparam logic [3:0] RS_PERIPH_FIRST = 4'ha;
  localparam int PERIPH_NUM = 6;
  localparam logic [1:0] TS_BYTE = 2'h0;
  localparam logic [1:0] TS_WORD = 2'h1;
  localparam logic [1:0] TS_LONG = 2'h2;
  localparam logic [1:0] TS_16BYTE = 2'h3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [2:0] OPER_RST = 3'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] rsrc;
    logic ds;
    logic tm;
    logic [1:0] ts;
    logic ie;
    logic te;
    logic de;
  } chan_ctrl_t;

  typedef struct packed {
    logic [1:0] size;
    logic burst;
    logic single;
    logic to_device;
  } unit_cmd_t;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_MOVE} chan_state_t;

endpackage

// *** hdl/request_detect.sv ***
// Request line conditioner: two-stage synchroniser plus falling edge
// detector per active-low request line. Assumes one clock, sync reset.
module request_detect #(
  parameter int W = 1
) (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic [W-1:0] req_n_i, // Active-low request lines
  output logic [W-1:0] low_o, // Synchronised line is low
  output logic [W-1:0] fall_o // One-cycle falling edge
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  // ----------------------------------------------------------------
  // Synchroniser; first stage feeds only the second
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_q <= '1;
      sync_q <= '1;
      prev_q <= '1;
    end
    else
    begin
      meta_q <= req_n_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Edge compares two successive synchronised samples
  assign low_o = ~sync_q;
  assign fall_o = prev_q & ~sync_q;

endmodule

// *** test/dma_channel_control_asserts.sv ***
// Port checker of one DMA channel control block.
// Assumes one clock and a synchronous active-high reset.
module dma_channel_control_asserts #(
  parameter int CHAN_ID = 0,
  parameter int CNT_W = 24
) (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Acknowledge
  input wire logic nmi_i, // NMI event
  input wire logic addr_err_i, // Address error event
  input wire logic unit_done_i, // Unit moved
  input wire logic unit_req_o, // Unit request
  input wire dma_pkg::unit_cmd_t unit_cmd_o, // Unit command
  input wire logic ext_acknowledge_o, // Pin acknowledge
  input wire logic completion_irq_o // Completion interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------
  // Recent causes
  // --------------------
  // An abort lands a few cycles after its cause, so three are kept
  logic [2:0] cause_q;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cause_q <= 3'h0;
    end
    else
    begin
      cause_q <= {cause_q[1:0], wb_ack_o | nmi_i | addr_err_i};
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  chk_bus_answer: assert property (s_taken |=> s_answer)
    else $error("bus request not answered in one cycle");
  chk_read_hold: assert property ($changed(wb_dat_o) |-> wb_ack_o && !$past(wb_we_i))
    else $error("read data changed without a read");
  chk_ext_ack: assert property (ext_acknowledge_o |-> unit_req_o && CHAN_ID < 2)
    else $error("pin acknowledge outside a pin transfer");
  chk_irq_cause: assert property ($rose(completion_irq_o) |->
    $past(unit_done_i) || $past(unit_done_i, 2) || (|cause_q))
    else $error("interrupt rose without completion");
  chk_irq_clear: assert property ($fell(completion_irq_o) |-> |cause_q)
    else $error("interrupt fell without a register write");
  chk_req_cause: assert property ($fell(unit_req_o) |->
    $past(unit_done_i) || (|cause_q))
    else $error("unit request dropped without cause");
  chk_nmi_stop: assert property (nmi_i |=> ##3 !unit_req_o)
    else $error("transfer not blocked after nmi");
  chk_err_stop: assert property (addr_err_i |=> ##3 !unit_req_o)
    else $error("transfer not blocked after address error");
  chk_cmd_steady: assert property (unit_req_o && $past(unit_req_o) |->
    $stable(unit_cmd_o))
    else $error("unit command changed during a request");
endmodule

bind dma_channel_control dma_channel_control_asserts #(.CHAN_ID(CHAN_ID), .CNT_W(CNT_W)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .nmi_i(nmi_i),
  .addr_err_i(addr_err_i), .unit_done_i(unit_done_i), .unit_req_o(unit_req_o),
  .unit_cmd_o(unit_cmd_o), .ext_acknowledge_o(ext_acknowledge_o),
  .completion_irq_o(completion_irq_o)
);

// *** test/ext_requester.sv ***
// Model of the external device on the request and acknowledge pins.
// Assumes the bench pulses go_i once for each transfer it wants.
module ext_requester (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic go_i, // Ask for one transfer
  input wire logic pulse_i, // Short low pulse instead of a held level
  input wire logic [3:0] dly_i, // Cycles of delay before asking
  input wire logic ack_i, // Acknowledge from the channel
  output logic req_n_o // Request pin, active low, idles high
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt_q;
  logic held_q;
  // --------------------
  // Request pin
  // --------------------
  // A level request stays low until acknowledged; a pulse gives one edge
  assign req_n_o = !(held_q || (cnt_q != 0 && cnt_q <= 3));
  always_ff @(posedge clk_i)
  begin
    if (rst_i || (ack_i && !pulse_i))
    begin
      cnt_q <= 0;
      held_q <= 1'b0;
    end
    else if (go_i)
    begin
      cnt_q <= int'(dly_i) + 4;
    end
    else if (cnt_q != 0)
    begin
      cnt_q <= cnt_q - 1;
      held_q <= held_q || (!pulse_i && cnt_q == 1);
    end
  end
endmodule

// *** test/dma_channel_control_tb_top.sv ***
// Self-checking bench of channel 0 of the DMA channel control block.
// Assumes the requester model and the bound port checker.
module dma_channel_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [3:0] sel_v = 4'hf;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic ext_request_n;
  logic [5:0] periph_req_n_i = 6'h3f;
  logic nmi_i = 1'b0;
  logic addr_err_i = 1'b0;
  logic unit_done_i = 1'b0;
  logic unit_req_o;
  dma_pkg::unit_cmd_t unit_cmd_o;
  logic ext_acknowledge_o;
  logic completion_irq_o;
  logic go = 1'b0;
  logic pulse_mode = 1'b0;
  logic [3:0] req_dly = 4'h0;
  int err_count = 0;
  int compares = 0;
  int seed = 32'h50fd;
  int cnt_m;
  int te_m = 0;
  int bad[6] = '{1, 5, 6, 7, 8, 9};
  int pin[3] = '{0, 2, 3};
  int oper_exp[4] = '{1, 0, 3, 5};
  logic [31:0] d;
  dma_channel_control #(.CHAN_ID(0), .CNT_W(24)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_request_n_i(ext_request_n),
    .periph_req_n_i(periph_req_n_i), .nmi_i(nmi_i), .addr_err_i(addr_err_i),
    .unit_done_i(unit_done_i), .unit_req_o(unit_req_o), .unit_cmd_o(unit_cmd_o),
    .ext_acknowledge_o(ext_acknowledge_o), .completion_irq_o(completion_irq_o)
  );
  ext_requester peer (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .pulse_i(pulse_mode),
    .dly_i(req_dly), .ack_i(ext_acknowledge_o), .req_n_o(ext_request_n));
  initial
  begin
    forever #20 clk_i = ~clk_i;
  end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    test_done();
  end
  // --------------------
  // Tasks
  // --------------------
  task automatic test_done();
    if (err_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] dw,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= dw;
    wb_sel_i <= sel_v;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1)
    begin
      err_count++;
      test_done();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dw);
    logic [31:0] q;
    bus(a, 1'b1, dw, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0000_0000, q);
    check($sformatf("read %h", a), exp, q);
  endtask
  task automatic quiet(input int n);
    logic moved;
    moved = 1'b0;
    repeat (n)
    begin
      @(posedge clk_i);
      moved = moved | (unit_req_o !== 1'b0);
    end
    check("no unit request", 32'h0000_0000, moved);
  endtask
  task automatic await_req();
    int k;
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (unit_req_o !== 1'b1 && k < 40);
    if (unit_req_o !== 1'b1)
    begin
      err_count++;
      test_done();
    end
  endtask
  // Model readback of the control register
  function automatic logic [31:0] ctrl_m(input logic [31:0] ctl);
    return (ctl & 32'h0000_0f7d) | (32'(te_m) << 1);
  endfunction
  task automatic xfer(input logic [31:0] ctl, input int n, input int src);
    logic [3:0] rs;
    int stall;
    rs = ctl[11:8];
    wr(dma_pkg::COUNT_OFS, n);
    cnt_m = n;
    wr(dma_pkg::CTRL_OFS, ctl);
    if (src != 0)
      quiet(8);
    repeat (n)
    begin
      @(posedge clk_i);
      go <= (src == 1);
      periph_req_n_i <= (src > 1) ? ~(6'h01 << (src - 2)) : 6'h3f;
      @(posedge clk_i);
      go <= 1'b0;
      await_req();
      periph_req_n_i <= 6'h3f;
      check("unit command", {ctl[4:3], ctl[5], rs[3:1] == 3'h1, rs == 4'h2},
            unit_cmd_o);
      check("pin acknowledge", src == 1, ext_acknowledge_o);
      stall = $random(seed) & 3;
      repeat (stall)
        @(posedge clk_i);
      unit_done_i <= 1'b1;
      @(posedge clk_i);
      unit_done_i <= 1'b0;
      cnt_m--;
    end
    te_m = 1;
    @(posedge clk_i);
    check("completion irq", ctl[2], completion_irq_o);
    rdc(dma_pkg::CTRL_OFS, ctrl_m(ctl));
    rdc(dma_pkg::COUNT_OFS, cnt_m);
    wr(dma_pkg::COUNT_OFS, 1);
    wr(dma_pkg::CTRL_OFS, ctl | 32'h0000_0002);
    quiet(8);
    rdc(dma_pkg::CTRL_OFS, ctrl_m(ctl));
    wr(dma_pkg::CTRL_OFS, 32'h0000_0000);
    te_m = 0;
    rdc(dma_pkg::CTRL_OFS, 32'h0000_0000);
    check("irq cleared", 32'h0000_0000, completion_irq_o);
  endtask
  // --------------------
  // Main sequence
  // --------------------
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(dma_pkg::CTRL_OFS, 32'h0000_0000);
    rdc(dma_pkg::OPER_OFS, 32'h0000_0000);
    rdc(dma_pkg::COUNT_OFS, 32'h0000_0000);
    rdc(dma_pkg::STATUS_OFS, 32'h0000_0000);
    repeat (6)
    begin
      d = $random(seed);
      wr(dma_pkg::CTRL_OFS, d & 32'hffff_fffe);
      rdc(dma_pkg::CTRL_OFS, d & 32'h0000_0f7c);
      // Low byte lane only: the source field in byte 1 must survive
      sel_v = 4'h1;
      wr(dma_pkg::CTRL_OFS, 32'h0000_0000);
      sel_v = 4'hf;
      rdc(dma_pkg::CTRL_OFS, d & 32'h0000_0f00);
      wr(dma_pkg::COUNT_OFS, d);
      rdc(dma_pkg::COUNT_OFS, d & 32'h00ff_ffff);
      wr(8'h10, d);
      rdc(8'h10, 32'h0000_0000);
    end
    wr(dma_pkg::CTRL_OFS, 32'h0000_0000);
    wr(dma_pkg::OPER_OFS, 32'h0000_0001);
    for (int i = 0; i < 16; i++)
      xfer(32'h0000_0401 | (i << 2), 2, 0);
    for (int c = 0; c < 6; c++)
    begin
      pulse_mode <= c[0];
      req_dly <= 4'($random(seed));
      xfer((pin[c / 2] << 8) | (c[0] << 6) | ($random(seed) & 'h38) | 5, 1, 1);
    end
    for (int k = 0; k < 6; k++)
      xfer(((10 + k) << 8) | ($random(seed) & 'h28) | 5, 1, k + 2);
    foreach (bad[i])
    begin
      wr(dma_pkg::COUNT_OFS, 1);
      wr(dma_pkg::CTRL_OFS, (bad[i] << 8) | 1);
      pulse_mode <= 1'b1;
      go <= 1'b1;
      periph_req_n_i <= 6'h00;
      @(posedge clk_i);
      go <= 1'b0;
      quiet(12);
      periph_req_n_i <= 6'h3f;
      wr(dma_pkg::CTRL_OFS, 32'h0000_0000);
    end
    for (int k = 0; k < 4; k++)
    begin
      wr(dma_pkg::COUNT_OFS, 3);
      wr(dma_pkg::CTRL_OFS, 32'h0000_0405);
      await_req();
      rdc(dma_pkg::STATUS_OFS, 32'h0000_000b);
      if (k == 0)
        wr(dma_pkg::CTRL_OFS, 32'h0000_0404);
      if (k == 1)
        wr(dma_pkg::OPER_OFS, 32'h0000_0000);
      nmi_i <= (k == 2);
      addr_err_i <= (k == 3);
      @(posedge clk_i);
      nmi_i <= 1'b0;
      addr_err_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      quiet(6);
      rdc(dma_pkg::CTRL_OFS, (k == 0) ? 32'h0000_0404 : 32'h0000_0405);
      rdc(dma_pkg::COUNT_OFS, 3);
      wr(dma_pkg::CTRL_OFS, 32'h0000_0000);
      rdc(dma_pkg::OPER_OFS, oper_exp[k]);
      wr(dma_pkg::OPER_OFS, 32'h0000_0001);
      rdc(dma_pkg::OPER_OFS, 32'h0000_0001);
    end
    wr(dma_pkg::OPER_OFS, 32'h0000_0007);
    rdc(dma_pkg::OPER_OFS, 32'h0000_0001);
    test_done();
  end
endmodule
